/* File: rtl/audio_path_clock_config_regs.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Clock rate code 0..5 selects 5.12 to 17.92 MHz input frequency.
// - Clock source bit 3 low drives clock output; high makes it high impedance.
// - Receive wideband data with automute enabled forces receive source to mute.
// - Receive bit 0 low connects expander; high bypasses it.
// - Receive source 00 mute, 01 expander, 10 aux; 11 forbidden.
// - Receive bit 3 sums sidetone input into receive summer when high.
// - Earpiece field: mute, first only, second only, or both differential.
// - Receive bit 6 high biases speaker terminals to mid rail internally.
// - Receive bit 7 low: single-ended minus pin; high: differential pair.
// - Power-off forces speaker output biases off regardless of settings.
// - Transmit wideband data with automute enabled mutes transmit summer.
// - Six-bit transmit register; bits 1:0 select mute, mic1, mic2, aux.
// - Transmit bit 2 low connects compressor; high bypasses it.
// - Transmit bits 3,4,5 gate voice, data and tone into summer.
// - Mic trim code selects sixteen gain steps; 1000 gives 0 dB.
// - Limit trim code offsets limit in 0.5 dB steps; 1010 is 0 dB.
// - Tone trim code selects sixteen steps; no zero-decibel setting.
module audio_path_clock_config_regs (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // Register port
  input  wire logic [7:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  // Mode inputs from the rest of the device
  input  wire logic                       automute_disable_bit,
  input  wire logic                       rx_wideband_active,
  input  wire logic                       tx_wideband_active,
  input  wire logic                       power_off,
  // Clock output pin control and decoded clock rate
  output logic                            clock_output_pin_oe_n,
  output logic      [14:0]                clock_freq_khz,
  output logic                            clock_code_illegal,
  // Decoded path controls
  output audio_cfg_pkg::rx_path_t         rx_path,
  output audio_cfg_pkg::tx_path_t         tx_path,
  output audio_cfg_pkg::trim_t            trim
);
  import audio_cfg_pkg::*;

  logic [3:0] clock_source_select;
  logic [7:0] receive_path_config;
  logic [5:0] transmit_path_config;
  logic [3:0] mic_tone_trim;
  logic [3:0] limit_level_trim;
  logic [3:0] tone_gain_trim;

  logic [1:0] rx_src;
  logic [1:0] ear_cfg;
  logic       rx_automute;
  logic       tx_automute;
  logic       spk_diff;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input logic [3:0] c,
                                          input logic [7:0] r,
                                          input logic [5:0] t,
                                          input logic [3:0] m,
                                          input logic [3:0] l,
                                          input logic [3:0] s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      clock_source_select_addr:  v = {4'h0, c};
      receive_path_config_addr:  v = r;
      transmit_path_config_addr: v = {2'h0, t};
      mic_tone_trim_addr:        v = {4'h0, m};
      limit_level_trim_addr:     v = {4'h0, l};
      tone_gain_trim_addr:       v = {4'h0, s};
      default:                   v = 8'h00;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register writes. Reset values pick a quiet path and 0 dB trims where
  // a 0 dB step exists, so the analog stages wake up muted and centred.

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clock_source_select  <= clock_source_select_rst;
      receive_path_config  <= receive_path_config_rst;
      transmit_path_config <= transmit_path_config_rst;
      mic_tone_trim        <= mic_tone_trim_rst;
      limit_level_trim     <= limit_level_trim_rst;
      tone_gain_trim       <= tone_gain_trim_rst;
    end else if (wr) begin
      case (addr)
        clock_source_select_addr:  clock_source_select  <= wdata[3:0];
        receive_path_config_addr:  receive_path_config  <= wdata;
        transmit_path_config_addr: transmit_path_config <= wdata[5:0];
        mic_tone_trim_addr:        mic_tone_trim        <= wdata[3:0];
        limit_level_trim_addr:     limit_level_trim     <= wdata[3:0];
        tone_gain_trim_addr:       tone_gain_trim       <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= read_mux(addr, clock_source_select, receive_path_config,
                        transmit_path_config, mic_tone_trim, limit_level_trim,
                        tone_gain_trim);
    end else begin
      rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock source.

  clock_rate_decode u_rate (
    .ref_clk         (ref_clk),
    .rstn            (rstn),
    .clock_rate_code (clock_source_select[clock_rate_code_lsb +: 3]),
    .freq_khz        (clock_freq_khz),
    .code_illegal    (clock_code_illegal)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clock_output_pin_oe_n <= 1'b0;
    end else begin
      clock_output_pin_oe_n <= clock_source_select[clock_output_tristate_bit];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive path decode.

  assign rx_automute = rx_wideband_active && !automute_disable_bit;
  assign tx_automute = tx_wideband_active && !automute_disable_bit;
  assign rx_src      = receive_path_config[receive_source_switch_lsb +: 2];
  assign ear_cfg     = receive_path_config[earpiece_output_config_lsb +: 2];
  assign spk_diff    = receive_path_config[speaker_diff_select_bit];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_path <= '0;
    end else begin
      rx_path.expander_bypassed <= receive_path_config[expander_bypass_bit];
      rx_path.expander_on       <= !receive_path_config[expander_bypass_bit];
      // The forbidden code 11 is decoded as mute so the path stays quiet.
      rx_path.rx_src_mute_sel     <= rx_automute || (rx_src != rx_src_expander &&
                                     rx_src != rx_src_aux);
      rx_path.rx_src_expander_sel <= !rx_automute && rx_src == rx_src_expander;
      rx_path.rx_src_aux_sel      <= !rx_automute && rx_src == rx_src_aux;
      rx_path.sidetone_summed   <= receive_path_config[sidetone_summer_bit];
      rx_path.earpiece_first_on <= ear_cfg == ear_first_only || ear_cfg == ear_diff;
      rx_path.earpiece_second_on <= ear_cfg == ear_second_only || ear_cfg == ear_diff;
      rx_path.earpiece_differential <= ear_cfg == ear_diff;
      rx_path.speaker_bias_on <= receive_path_config[speaker_bias_internal_bit] &&
                                 !power_off;
      rx_path.speaker_minus_on <= !power_off;
      rx_path.speaker_plus_on  <= spk_diff && !power_off;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit path decode. Automute acts at the summer, so all three gates
  // close while the source switch keeps its programmed setting.

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_path <= '0;
    end else begin
      case (transmit_path_config[transmit_source_select_lsb +: 2])
        tx_src_mic1: tx_path.source <= tx_mic_first;
        tx_src_mic2: tx_path.source <= tx_mic_second;
        tx_src_aux:  tx_path.source <= tx_aux;
        default:     tx_path.source <= tx_mute;
      endcase
      tx_path.compressor_on <= !transmit_path_config[compressor_bypass_bit];
      tx_path.voice_on <= transmit_path_config[tx_voice_gate_bit] && !tx_automute;
      tx_path.data_on  <= transmit_path_config[tx_data_gate_bit] && !tx_automute;
      tx_path.tone_on  <= transmit_path_config[tx_tone_gate_bit] && !tx_automute;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trim codes go to the analog stages unchanged; each stage holds its own
  // gain table.

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trim <= {mic_tone_trim_rst, limit_level_trim_rst, tone_gain_trim_rst};
    end else begin
      trim.mic_trim_code   <= mic_tone_trim;
      trim.limit_trim_code <= limit_level_trim;
      trim.tone_trim_code  <= tone_gain_trim;
    end
  end

endmodule // audio_path_clock_config_regs

/* File: rtl/audio_cfg_pkg.sv */
package audio_cfg_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] clock_source_select_addr  = 8'h31;
  localparam logic [7:0] receive_path_config_addr  = 8'h32;
  localparam logic [7:0] transmit_path_config_addr = 8'h33;
  localparam logic [7:0] mic_tone_trim_addr        = 8'h34;
  localparam logic [7:0] limit_level_trim_addr     = 8'h35;
  localparam logic [7:0] tone_gain_trim_addr       = 8'h36;

  // Reset values.
  localparam logic [3:0] clock_source_select_rst  = 4'h0;
  localparam logic [7:0] receive_path_config_rst  = 8'h00;
  localparam logic [5:0] transmit_path_config_rst = 6'h00;
  localparam logic [3:0] mic_tone_trim_rst        = 4'h8;
  localparam logic [3:0] limit_level_trim_rst     = 4'ha;
  localparam logic [3:0] tone_gain_trim_rst       = 4'h8;

  // Field positions.
  localparam int clock_rate_code_lsb        = 0;
  localparam int clock_output_tristate_bit  = 3;
  localparam int expander_bypass_bit        = 0;
  localparam int receive_source_switch_lsb  = 1;
  localparam int sidetone_summer_bit        = 3;
  localparam int earpiece_output_config_lsb = 4;
  localparam int speaker_bias_internal_bit  = 6;
  localparam int speaker_diff_select_bit    = 7;
  localparam int transmit_source_select_lsb = 0;
  localparam int compressor_bypass_bit      = 2;
  localparam int tx_voice_gate_bit          = 3;
  localparam int tx_data_gate_bit           = 4;
  localparam int tx_tone_gate_bit           = 5;

  // Receive source and earpiece codes.
  localparam logic [1:0] rx_src_mute     = 2'h0;
  localparam logic [1:0] rx_src_expander = 2'h1;
  localparam logic [1:0] rx_src_aux      = 2'h2;
  localparam logic [1:0] ear_both_mute   = 2'h0;
  localparam logic [1:0] ear_first_only  = 2'h1;
  localparam logic [1:0] ear_second_only = 2'h2;
  localparam logic [1:0] ear_diff        = 2'h3;

  // Transmit source codes.
  localparam logic [1:0] tx_src_mute   = 2'h0;
  localparam logic [1:0] tx_src_mic1   = 2'h1;
  localparam logic [1:0] tx_src_mic2   = 2'h2;
  localparam logic [1:0] tx_src_aux    = 2'h3;

  // Input frequency, in kHz, for each legal clock rate code.
  localparam logic [14:0] freq_khz_0 = 15'd5120;
  localparam logic [14:0] freq_khz_1 = 15'd7680;
  localparam logic [14:0] freq_khz_2 = 15'd10240;
  localparam logic [14:0] freq_khz_3 = 15'd12800;
  localparam logic [14:0] freq_khz_4 = 15'd15360;
  localparam logic [14:0] freq_khz_5 = 15'd17920;

  typedef enum logic [1:0] {
    tx_mute,
    tx_mic_first,
    tx_mic_second,
    tx_aux
  } tx_source_t;

  typedef struct packed {
    logic       expander_on;
    logic       expander_bypassed;
    logic       rx_src_mute_sel;
    logic       rx_src_expander_sel;
    logic       rx_src_aux_sel;
    logic       sidetone_summed;
    logic       earpiece_first_on;
    logic       earpiece_second_on;
    logic       earpiece_differential;
    logic       speaker_bias_on;
    logic       speaker_minus_on;
    logic       speaker_plus_on;
  } rx_path_t;

  typedef struct packed {
    tx_source_t source;
    logic       compressor_on;
    logic       voice_on;
    logic       data_on;
    logic       tone_on;
  } tx_path_t;

  typedef struct packed {
    logic [3:0] mic_trim_code;
    logic [3:0] limit_trim_code;
    logic [3:0] tone_trim_code;
  } trim_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

/* File: rtl/clock_rate_decode.sv */
`timescale 1ns/1ps
module clock_rate_decode (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // Code in
  input  wire logic [2:0]              clock_rate_code,
  // Decoded frequency
  output logic      [14:0]             freq_khz,
  output logic                         code_illegal
);
  import audio_cfg_pkg::*;

  // Codes 6 and 7 are forbidden; they report zero and raise a flag.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      freq_khz     <= freq_khz_0;
      code_illegal <= 1'b0;
    end else begin
      code_illegal <= 1'b0;
      case (clock_rate_code)
        3'h0: freq_khz <= freq_khz_0;
        3'h1: freq_khz <= freq_khz_1;
        3'h2: freq_khz <= freq_khz_2;
        3'h3: freq_khz <= freq_khz_3;
        3'h4: freq_khz <= freq_khz_4;
        3'h5: freq_khz <= freq_khz_5;
        default: begin
          freq_khz     <= 15'h0000;
          code_illegal <= 1'b1;
        end
      endcase
    end
  end

endmodule // clock_rate_decode

/* File: testbench/audio_cfg_checker.sv */
`timescale 1ns/1ps
module audio_cfg_checker (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rstn,
  // Register port
  input wire logic [7:0]               addr,
  input wire logic [7:0]               wdata,
  input wire logic                     wr,
  input wire logic                     rd,
  input wire logic [7:0]               rdata,
  // Mode inputs
  input wire logic                     automute_disable_bit,
  input wire logic                     rx_wideband_active,
  input wire logic                     tx_wideband_active,
  input wire logic                     power_off,
  // Decoded outputs
  input wire logic                     clock_output_pin_oe_n,
  input wire logic [14:0]              clock_freq_khz,
  input wire logic                     clock_code_illegal,
  input wire audio_cfg_pkg::rx_path_t  rx_path,
  input wire audio_cfg_pkg::tx_path_t  tx_path,
  input wire audio_cfg_pkg::trim_t     trim
);
  import audio_cfg_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Writes land in the register one edge late and in the decoded outputs one more.
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  clk_oe_a: assert property (wr && addr == 8'h31 |-> ##2 clock_output_pin_oe_n == $past(wdata[3], 2))
    else $error("clock pin enable wrong");
  clk_slow_a: assert property (wr && addr == 8'h31 && wdata[2:0] == 3'h0 |-> ##2
    clock_freq_khz == 15'h1400 && !clock_code_illegal) else $error("clock code 0 wrong");
  clk_bad_a: assert property (wr && addr == 8'h31 && wdata[2:1] == 2'h3 |-> ##2
    clock_code_illegal && clock_freq_khz == 15'h0000) else $error("forbidden code not flagged");
  exp_pair_a: assert property (wr && addr == 8'h32 |-> ##2 rx_path.expander_bypassed ==
    $past(wdata[0], 2) && rx_path.expander_on != rx_path.expander_bypassed) else $error("expander wrong");
  rx_mute_a: assert property (rx_wideband_active && !automute_disable_bit |=>
    rx_path.rx_src_mute_sel && !rx_path.rx_src_aux_sel && !rx_path.rx_src_expander_sel)
    else $error("receive automute missing");
  tx_mute_a: assert property (tx_wideband_active && !automute_disable_bit |=>
    !tx_path.voice_on && !tx_path.data_on && !tx_path.tone_on) else $error("transmit automute missing");
  spk_off_a: assert property (power_off |=> !rx_path.speaker_bias_on && !rx_path.speaker_minus_on
    && !rx_path.speaker_plus_on) else $error("speaker bias on in power off");
  tx_src_a: assert property (wr && addr == 8'h33 |-> ##2 tx_path.source == $past(wdata[1:0], 2)
    && tx_path.compressor_on == !$past(wdata[2], 2)) else $error("transmit source wrong");
  trim_read_a: assert property (rd && addr == 8'h34 |=> rdata == {4'h0, trim.mic_trim_code})
    else $error("mic trim readback differs");
  cover property (wr && addr == 8'h31 && wdata[2:1] == 2'h3);
  cover property (rx_wideband_active && tx_wideband_active && !automute_disable_bit);
  cover property (power_off && rx_path.speaker_bias_on == 1'b0);
endmodule // audio_cfg_checker
bind audio_path_clock_config_regs audio_cfg_checker i_audio_cfg_checker (.ref_clk, .rstn, .addr,
  .wdata, .wr, .rd, .rdata, .automute_disable_bit, .rx_wideband_active, .tx_wideband_active,
  .power_off, .clock_output_pin_oe_n, .clock_freq_khz, .clock_code_illegal, .rx_path, .tx_path, .trim);

/* File: testbench/audio_path_clock_config_regs_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("BAD %0t mismatch", $time); end end
module audio_path_clock_config_regs_test;
  import audio_cfg_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic automute_disable_bit = 1'b0, rx_wideband_active = 1'b0, tx_wideband_active = 1'b0;
  logic power_off = 1'b0, clock_output_pin_oe_n, clock_code_illegal;
  logic [14:0] clock_freq_khz;
  rx_path_t rx_path;
  tx_path_t tx_path;
  trim_t trim;
  int err_count = 0, samples_checked = 0;
  logic [14:0] freq_tab [8] = '{15'h1400, 15'h1e00, 15'h2800, 15'h3200, 15'h3c00, 15'h4600, 15'h0, 15'h0};
  logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0a, 8'h08};
  audio_path_clock_config_regs i_audio_path_clock_config_regs (.ref_clk, .rstn, .addr, .wdata,
    .wr, .rd, .rdata, .automute_disable_bit, .rx_wideband_active, .tx_wideband_active, .power_off,
    .clock_output_pin_oe_n, .clock_freq_khz, .clock_code_illegal, .rx_path, .tx_path, .trim);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= r;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    put(a, d, 1'b1, 1'b0);
  endtask
  // Read data stand only in the cycle after the strobe, so they are looked at there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    put(a, 8'h00, 1'b0, 1'b1);
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic settle;
    put(addr, wdata, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic mode(input logic [3:0] m);
    @(posedge ref_clk);
    {automute_disable_bit, rx_wideband_active, tx_wideband_active, power_off} <= m;
    // A write strobe left high by the previous call must not repeat the write.
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic rx_path_t rx_exp(input logic [7:0] v, input logic m, input logic po);
    return '{~v[0], v[0], m | (v[2:1] == 2'h0) | (v[2:1] == 2'h3), ~m & (v[2:1] == 2'h1),
      ~m & (v[2:1] == 2'h2), v[3], v[4], v[5], &v[5:4], v[6] & ~po, ~po, v[7] & ~po};
  endfunction
  function automatic tx_path_t tx_exp(input logic [7:0] v, input logic m);
    return '{tx_source_t'(v[1:0]), ~v[2], v[3] & ~m, v[4] & ~m, v[5] & ~m};
  endfunction
  task automatic do_reset;
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(trim, 12'h8a8)
    `CHK(clock_freq_khz, 15'h1400)
    @(posedge ref_clk);
    rstn <= 1'b1;
    settle;
    `CHK(rx_path, rx_exp(8'h00, 1'b0, 1'b0))
    `CHK(tx_path, tx_exp(8'h00, 1'b0))
    for (int i = 0; i < 6; i++) rd_chk(8'(8'h31 + i), rst_tab[i]);
    $display("test reset done");
  endtask
  task automatic print_verdict;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    err_count++;
    print_verdict;
  end
  initial begin
    logic [7:0] d;
    do_reset;
    for (int c = 0; c < 8; c++) begin
      d = {4'hf, 1'(c), 3'(c)};
      wr_reg(8'h31, d);
      settle;
      `CHK(clock_freq_khz, freq_tab[c])
      `CHK(clock_code_illegal, c >= 6)
      `CHK(clock_output_pin_oe_n, d[3])
      rd_chk(8'h31, {4'h0, d[3:0]});
    end
    wr_reg(8'h30, 8'hff);
    wr_reg(8'h37, 8'hff);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h37, 8'h00);
    rd_chk(8'h31, 8'h0f);
    $display("test clock done");
    for (int v = 0; v < 256; v++) begin
      wr_reg(8'h32, 8'(v));
      settle;
      `CHK(rx_path, rx_exp(8'(v), 1'b0, 1'b0))
      rd_chk(8'h32, 8'(v));
    end
    for (int v = 0; v < 64; v++) begin
      wr_reg(8'h33, {2'h3, 6'(v)});
      settle;
      `CHK(tx_path, tx_exp(8'(v), 1'b0))
      rd_chk(8'h33, {2'h0, 6'(v)});
    end
    for (int k = 0; k < 16; k++) begin
      wr_reg(8'h34, {4'ha, 4'(k)});
      wr_reg(8'h35, {4'h5, ~4'(k)});
      wr_reg(8'h36, {4'hc, 4'(k) ^ 4'h5});
      settle;
      `CHK(trim, {4'(k), ~4'(k), 4'(k) ^ 4'h5})
      rd_chk(8'h35, {4'h0, ~4'(k)});
    end
    $display("test paths done");
    wr_reg(8'h32, 8'h02);
    wr_reg(8'h33, 8'h39);
    for (int m = 0; m < 8; m++) begin
      mode({3'(m), 1'b0});
      settle;
      `CHK(rx_path, rx_exp(8'h02, ~m[2] & m[1], 1'b0))
      `CHK(tx_path, tx_exp(8'h39, ~m[2] & m[0]))
    end
    wr_reg(8'h32, 8'hc0);
    for (int p = 0; p < 2; p++) begin
      mode({3'h4, 1'(p)});
      settle;
      `CHK(rx_path, rx_exp(8'hc0, 1'b0, 1'(p)))
    end
    mode(4'h0);
    $display("test modes done");
    do_reset;
    print_verdict;
  end
endmodule // audio_path_clock_config_regs_test
